// File: xbu_core.sv
// external bus unit: window decode, bus sequencing and pin driving
`timescale 1ns/1ps
`default_nettype none
module xbu_core (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic link_clk,
    input wire logic link_rst,
    input wire logic single_chip_mode,
    input wire logic [2:0] segment_lines,
    input wire logic [95:0] window_address_select_base,
    input wire logic [95:0] window_address_select_mask,
    input wire logic [3:0] window_enable,
    input wire logic [24:0] window_timing_config,
    input wire logic [14:0] window_function_config,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [23:0] req_addr,
    input wire logic [15:0] req_wdata,
    output logic req_done,
    output logic req_error,
    output logic [15:0] req_rdata,
    output logic busy,
    input wire logic bus_ready_pin,
    output logic bus_reference_clock_out,
    output logic [23:0] addr_out,
    output logic [15:0] ad_out,
    output logic [15:0] ad_oe,
    input wire logic [15:0] ad_in,
    output logic [15:0] low_addr_out,
    output logic ale,
    output logic rd_n,
    output logic wr_n,
    output logic [4:0] cs_n,
    output logic ipb_sel,
    output logic ipb_cs_n,
    output logic [15:0] ipb_rdata_hold
);
    // ==========================================================
    // request capture and window selection
    // ==========================================================
    logic [2:0] set_idx;
    logic [23:0] addr_mask;
    logic is_ipb;
    xbu_win_decode u_dec (
        .addr(req_addr),
        .win_base(window_address_select_base),
        .win_mask(window_address_select_mask),
        .win_enable(window_enable),
        .set_idx(set_idx)
    );
    assign is_ipb = (req_addr >= xbu_pkg::IPB_BASE) && (req_addr <= xbu_pkg::IPB_LIMIT);
    // segment lines widen the space from 64 Kbytes upward, capped at 8 Mbytes
    assign addr_mask = (xbu_pkg::ADDR_MASK_64K << segment_lines | xbu_pkg::ADDR_MASK_64K)
        & xbu_pkg::ADDR_MASK_8M;

    // ==========================================================
    // crossing: request toggle into link domain, done toggle back
    // ==========================================================
    logic req_tgl_ff, done_sync, done_prev_ff, pending_ff;
    logic [23:0] cap_addr_ff;
    logic [15:0] cap_wdata_ff;
    logic cap_write_ff, cap_ipb_ff;
    logic [2:0] cap_set_ff;
    logic [15:0] lk_rdata_ff;
    logic lk_done_tgl_ff;
    logic nxt_start;
    // the done pulse blocks one cycle, so a request still held at that edge is not taken twice
    assign nxt_start = req_valid && !pending_ff && !req_done;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            req_tgl_ff <= 1'b0;
            pending_ff <= 1'b0;
            cap_addr_ff <= '0;
            cap_wdata_ff <= '0;
            cap_write_ff <= 1'b0;
            cap_ipb_ff <= 1'b0;
            cap_set_ff <= '0;
        end else if (nxt_start && !single_chip_mode) begin
            req_tgl_ff <= ~req_tgl_ff;
            pending_ff <= 1'b1;
            cap_addr_ff <= req_addr & addr_mask;
            cap_wdata_ff <= req_wdata;
            cap_write_ff <= req_write;
            cap_ipb_ff <= is_ipb;
            cap_set_ff <= set_idx;
        end else if (done_sync != done_prev_ff) begin
            pending_ff <= 1'b0;
        end
    end
    xbu_sync u_done_sync (.clk(sys_clk), .rst(rst), .d(lk_done_tgl_ff), .q(done_sync));
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            done_prev_ff <= 1'b0;
            req_done <= 1'b0;
            req_error <= 1'b0;
            req_rdata <= '0;
            busy <= 1'b0;
        end else begin
            done_prev_ff <= done_sync;
            // single chip mode answers at once with an error, no bus cycle
            req_done <= (done_sync != done_prev_ff) || (nxt_start && single_chip_mode);
            req_error <= nxt_start && single_chip_mode;
            if (done_sync != done_prev_ff) req_rdata <= lk_rdata_ff;
            busy <= pending_ff || (nxt_start && !single_chip_mode);
        end
    end

    // ==========================================================
    // link domain bus sequencer (capture regs stable while pending)
    // ==========================================================
    logic req_sync, req_prev_ff;
    xbu_sync u_req_sync (.clk(link_clk), .rst(link_rst), .d(req_tgl_ff), .q(req_sync));
    xbu_pkg::xbu_state_e st_ff;
    logic [3:0] wait_ff;
    logic [4:0] tcfg;
    logic [2:0] fcfg;
    logic mode_mux, mode_8bit, rdy_en, rdy_pol;
    logic rdy_sync, clk_half_ff;
    assign tcfg = window_timing_config[cap_set_ff*5 +: 5];
    assign fcfg = window_function_config[cap_set_ff*3 +: 3];
    assign mode_mux = fcfg[0];
    assign mode_8bit = fcfg[1];
    assign rdy_en = tcfg[4];
    assign rdy_pol = fcfg[2];
    xbu_sync u_rdy_sync (.clk(link_clk), .rst(link_rst), .d(bus_ready_pin), .q(rdy_sync));
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            st_ff <= xbu_pkg::XBU_IDLE;
            wait_ff <= '0;
            req_prev_ff <= 1'b0;
            lk_done_tgl_ff <= 1'b0;
            lk_rdata_ff <= '0;
        end else begin
            req_prev_ff <= req_sync;
            unique case (st_ff)
                xbu_pkg::XBU_IDLE: begin
                    if (req_sync != req_prev_ff) st_ff <= xbu_pkg::XBU_ADDR;
                end
                xbu_pkg::XBU_ADDR: begin
                    st_ff <= xbu_pkg::XBU_DATA;
                    wait_ff <= tcfg[3:0];
                end
                xbu_pkg::XBU_DATA: begin
                    if (wait_ff != '0) wait_ff <= wait_ff - 4'h1;
                    else if (!rdy_en || (rdy_sync == rdy_pol)) begin
                        st_ff <= xbu_pkg::XBU_DONE;
                    end
                end
                xbu_pkg::XBU_DONE: begin
                    // strobes are registered, so read data is valid only one cycle later
                    lk_rdata_ff <= mode_8bit ? {8'h00, ad_in[7:0]} : ad_in;
                    st_ff <= xbu_pkg::XBU_IDLE;
                    lk_done_tgl_ff <= ~lk_done_tgl_ff;
                end
            endcase
        end
    end

    // ==========================================================
    // pin outputs, all registered on the link clock rising edge
    // ==========================================================
    logic active;
    assign active = (st_ff == xbu_pkg::XBU_ADDR) || (st_ff == xbu_pkg::XBU_DATA);
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            clk_half_ff <= 1'b0;
            bus_reference_clock_out <= 1'b0;
        end else begin
            clk_half_ff <= ~clk_half_ff;
            bus_reference_clock_out <= ~clk_half_ff;
        end
    end
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            addr_out <= '0;
            ad_out <= '0;
            ad_oe <= '0;
            low_addr_out <= '0;
            ale <= 1'b0;
            rd_n <= 1'b1;
            wr_n <= 1'b1;
            cs_n <= xbu_pkg::CS_ALL_OFF;
            ipb_sel <= 1'b0;
            ipb_cs_n <= 1'b1;
            ipb_rdata_hold <= '0;
        end else begin
            ale <= (st_ff == xbu_pkg::XBU_ADDR) && mode_mux;
            addr_out <= active && !cap_ipb_ff ? cap_addr_ff : '0;
            low_addr_out <= active && !mode_mux ? cap_addr_ff[15:0] : '0;
            // mux mode puts the address on the shared lines during the address phase
            if (st_ff == xbu_pkg::XBU_ADDR && mode_mux) begin
                ad_out <= cap_addr_ff[15:0];
                ad_oe <= 16'hFFFF;
            end else if (st_ff == xbu_pkg::XBU_DATA && cap_write_ff) begin
                ad_out <= mode_8bit ? {8'h00, cap_wdata_ff[7:0]} : cap_wdata_ff;
                ad_oe <= mode_8bit ? 16'h00FF : 16'hFFFF;
            end else begin
                ad_out <= '0;
                ad_oe <= '0;
            end
            rd_n <= !(st_ff == xbu_pkg::XBU_DATA && !cap_write_ff);
            wr_n <= !(st_ff == xbu_pkg::XBU_DATA && cap_write_ff);
            // peripheral-bus accesses run the same sequence and strobes but hold addr_out at zero and cs_n all high
            ipb_sel <= active && cap_ipb_ff;
            ipb_cs_n <= !(active && cap_ipb_ff);
            if (st_ff == xbu_pkg::XBU_DATA && cap_ipb_ff) ipb_rdata_hold <= ad_in;
            cs_n <= xbu_pkg::CS_ALL_OFF;
            if (active && !cap_ipb_ff) cs_n[cap_set_ff] <= 1'b0;
        end
    end
endmodule // xbu_core
`default_nettype wire

// File: xbu_pkg.sv
// package: constants and types for the external bus unit
package xbu_pkg;
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int NWIN = 4;
    localparam int NCS = 5;
    localparam int WAIT_W = 4;
    localparam int SEG_W = 3;
    localparam logic [23:0] ADDR_MASK_64K = 24'h00FFFF;
    localparam logic [23:0] ADDR_MASK_8M = 24'h7FFFFF;
    localparam logic [2:0] SEG_LINES_MAX = 3'h7;
    localparam logic [4:0] CS_ALL_OFF = 5'h1F;
    localparam logic [23:0] IPB_BASE = 24'h200000;
    localparam logic [23:0] IPB_LIMIT = 24'h20FFFF;
    localparam logic [3:0] WAIT_RESET = 4'h1;
    localparam logic [1:0] CLK_DIV_HALF = 2'h1;
    typedef enum logic [1:0] {XBU_IDLE, XBU_ADDR, XBU_DATA, XBU_DONE} xbu_state_e;
endpackage

// File: xbu_sync.sv
// two-flop synchroniser for one level
`timescale 1ns/1ps
`default_nettype none
module xbu_sync (
    input wire logic clk,
    input wire logic rst,
    input wire logic d,
    output logic q
);
    logic meta_ff;
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_ff <= 1'b0;
            q <= 1'b0;
        end else begin
            meta_ff <= d;
            q <= meta_ff;
        end
    end
endmodule // xbu_sync
`default_nettype wire

// File: xbu_win_decode.sv
// window decoder: selects the configuration set hit by an address
`timescale 1ns/1ps
`default_nettype none
module xbu_win_decode (
    input wire logic [23:0] addr,
    input wire logic [95:0] win_base,
    input wire logic [95:0] win_mask,
    input wire logic [3:0] win_enable,
    output logic [2:0] set_idx
);
    logic [3:0] hit;
    genvar g;
    generate
        for (g = 0; g < xbu_pkg::NWIN; g++) begin : g_hit
            assign hit[g] = win_enable[g] &&
                ((addr & win_mask[g*24 +: 24]) == (win_base[g*24 +: 24] & win_mask[g*24 +: 24]));
        end
    endgenerate
    // window 4 over 3, window 2 over 1; default set zero when nothing hits
    always_comb begin
        if (hit[3]) set_idx = 3'h4;
        else if (hit[2]) set_idx = 3'h3;
        else if (hit[1]) set_idx = 3'h2;
        else if (hit[0]) set_idx = 3'h1;
        else set_idx = 3'h0;
    end
endmodule // xbu_win_decode
`default_nettype wire

// File: xbu_props.sv
// checker: pin and handshake assertions for the external bus unit
`timescale 1ns/1ps
`default_nettype none
module xbu_props (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic link_clk,
    input wire logic link_rst,
    input wire logic single_chip_mode,
    input wire logic [2:0] segment_lines,
    input wire logic req_valid,
    input wire logic req_done,
    input wire logic req_error,
    input wire logic bus_reference_clock_out,
    input wire logic [23:0] addr_out,
    input wire logic ale,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [4:0] cs_n,
    input wire logic ipb_cs_n
);
    // ====
    // helpers
    wire logic [23:0] seg_mask = (24'h000001 << (5'h10 + 5'(segment_lines))) - 24'h000001;
    wire logic sel = (cs_n != 5'h1F) || !ipb_cs_n;
    sequence s_req;
        $rose(req_valid);
    endsequence
    // ====
    // assertions
    a_err_with_done: assert property (@(posedge sys_clk) disable iff (rst)
        req_error |-> req_done) else $error("error flag without done");
    a_chip_err: assert property (@(posedge sys_clk) disable iff (rst)
        single_chip_mode && req_done |-> req_error) else $error("no error in single chip");
    a_chip_quiet: assert property (@(posedge link_clk) disable iff (link_rst)
        single_chip_mode |-> !sel && rd_n && wr_n) else $error("bus active in single chip");
    a_one_select: assert property (@(posedge link_clk) disable iff (link_rst)
        $onehot0({~cs_n, ~ipb_cs_n})) else $error("several selects low");
    a_strobe_select: assert property (@(posedge link_clk) disable iff (link_rst)
        !rd_n || !wr_n |-> sel) else $error("strobe without select");
    a_ale_select: assert property (@(posedge link_clk) disable iff (link_rst)
        ale |-> sel) else $error("latch pulse without select");
    a_ref_div: assert property (@(posedge link_clk) disable iff (link_rst)
        1'b1 |=> bus_reference_clock_out != $past(bus_reference_clock_out))
        else $error("reference clock stalled");
    a_addr_space: assert property (@(posedge link_clk) disable iff (link_rst)
        cs_n != 5'h1F |-> (addr_out & ~seg_mask) == 24'h000000)
        else $error("address beyond segment lines");
    a_req_answer: assert property (@(posedge sys_clk) disable iff (rst)
        s_req |-> ##[1:60] req_done) else $error("request not answered");
endmodule // xbu_props
bind xbu_core xbu_props u_props (.sys_clk, .rst, .link_clk, .link_rst, .single_chip_mode,
    .segment_lines, .req_valid, .req_done, .req_error, .bus_reference_clock_out, .addr_out,
    .ale, .rd_n, .wr_n, .cs_n, .ipb_cs_n);
`default_nettype wire

// File: xbu_mem_model.sv
// partner: external memory on the shared address/data bus with a ready line
`timescale 1ns/1ps
`default_nettype none
module xbu_mem_model (
    input wire logic link_clk,
    input wire logic [4:0] cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [23:0] addr_out,
    input wire logic [15:0] ad_out,
    input wire logic [7:0] dly,
    input wire logic lvl,
    output logic [15:0] ad_in,
    output logic ready_pin
);
    logic [15:0] mem [0:255];
    logic [15:0] last = 16'h0000;
    logic [7:0] cnt = 8'h00;
    wire logic sel = (cs_n != 5'h1F);
    always @(posedge link_clk) begin
        cnt <= (sel && !(rd_n && wr_n)) ? cnt + 8'h01 : 8'h00;
        last <= ad_in;
        if (sel && !wr_n) begin
            mem[addr_out[7:0]] <= ad_out;
        end
    end
    // released bus toggles so a stale value never looks like data
    assign ad_in = (sel && !rd_n) ? mem[addr_out[7:0]] : ~last;
    assign ready_pin = (cnt >= dly) ? lvl : ~lvl;
endmodule // xbu_mem_model
`default_nettype wire

// File: xbu_core_tb.sv
// testbench: directed accesses over windows, modes, peripheral bus and single chip
`timescale 1ns/1ps
`default_nettype none
module xbu_core_tb;
    logic sys_clk = 1'b0;
    logic link_clk = 1'b0;
    logic rst = 1'b1;
    logic link_rst = 1'b1;
    logic single_chip_mode = 1'b0;
    logic [3:0] window_enable = 4'hF;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic [23:0] req_addr = 24'h000000;
    logic [15:0] req_wdata = 16'h0000;
    logic [7:0] dly = 8'h03;
    logic lvl = 1'b0;
    logic req_done, req_error, bus_ready_pin, bus_reference_clock_out, ale, rd_n, wr_n, ipb_cs_n;
    logic [15:0] req_rdata, ad_out, ad_in, rdata;
    logic [23:0] addr_out;
    logic [4:0] cs_n;
    logic [4:0] cs_seen = 5'h00;
    logic ale_seen = 1'b0;
    logic ipb_seen = 1'b0;
    logic err_seen;
    int lat;
    int n_fail = 0;
    int check_count = 0;
    logic [23:0] adr_tab [4] = '{24'h000040, 24'h012345, 24'h010005, 24'h030007};
    logic [4:0] cs_tab [4] = '{5'h01, 5'h02, 5'h04, 5'h10};
    xbu_core dut (.sys_clk, .rst, .link_clk, .link_rst, .single_chip_mode,
        .segment_lines(3'h7), .window_enable, .req_valid, .req_write, .req_addr, .req_wdata,
        .window_address_select_base({24'h030000, 24'h030000, 24'h010000, 24'h010000}),
        .window_address_select_mask({24'hFF0000, 24'hFF0000, 24'hFFFF00, 24'hFF0000}),
        .window_timing_config({5'h10, 5'h03, 5'h11, 5'h00, 5'h02}),
        .window_function_config({3'h3, 3'h0, 3'h4, 3'h0, 3'h0}),
        .req_done, .req_error, .req_rdata, .busy(), .bus_ready_pin, .bus_reference_clock_out,
        .addr_out, .ad_out, .ad_oe(), .ad_in, .low_addr_out(), .ale, .rd_n, .wr_n, .cs_n,
        .ipb_sel(), .ipb_cs_n, .ipb_rdata_hold());
    xbu_mem_model mem (.link_clk, .cs_n, .rd_n, .wr_n, .addr_out, .ad_out, .dly, .lvl,
        .ad_in, .ready_pin(bus_ready_pin));
    // ====
    // clocks and pin monitor
    initial forever #25 sys_clk = ~sys_clk;
    initial begin
        #3;
        forever #7.5 link_clk = ~link_clk;
    end
    always @(posedge link_clk) if (req_valid) begin
        cs_seen <= cs_seen | ~cs_n;
        ale_seen <= ale_seen | ale;
        ipb_seen <= ipb_seen | ~ipb_cs_n;
    end
    // ====
    // tasks
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    // request is held until the done pulse, then dropped for one cycle
    task automatic acc(input logic w, input logic [23:0] a, input logic [15:0] d);
        cs_seen <= 5'h00;
        ale_seen <= 1'b0;
        ipb_seen <= 1'b0;
        req_valid <= 1'b1;
        req_write <= w;
        req_addr <= a;
        req_wdata <= d;
        lat = 0;
        do begin
            @(posedge sys_clk);
            lat++;
        end while (req_done !== 1'b1 && lat < 200);
        rdata = req_rdata;
        err_seen = req_error;
        req_valid <= 1'b0;
        if (lat >= 200) begin
            n_fail++;
            end_of_test();
        end
        @(posedge sys_clk);
    endtask
    // ====
    // scenarios
    initial begin
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        link_rst <= 1'b0;
        @(posedge sys_clk);
        for (int i = 0; i < 4; i++) begin
            lvl <= (i == 2);
            acc(1'b1, adr_tab[i], 16'hA5C0 + 16'(i));
            acc(1'b0, adr_tab[i], 16'h0000);
            chk(24'(cs_seen), 24'(cs_tab[i]));
            chk(24'(ale_seen), 24'(i == 3));
            chk(24'(rdata), (i == 3) ? 24'h0000C3 : 24'h00A5C0 + 24'(i));
        end
        window_enable <= 4'h7;
        acc(1'b0, 24'h030007, 16'h0000);
        chk(24'(cs_seen), 24'h000008);
        window_enable <= 4'hF;
        dly <= 8'h28;
        acc(1'b0, 24'h012345, 16'h0000);
        chk(24'(rdata), 24'h00A5C1);
        chk(24'(lat < 10), 24'h000001);
        lvl <= 1'b1;
        acc(1'b0, 24'h010005, 16'h0000);
        chk(24'(rdata), 24'h00A5C2);
        chk(24'(lat > 12), 24'h000001);
        acc(1'b1, 24'h200010, 16'h1234);
        chk(24'({ipb_seen, cs_seen}), 24'h000020);
        single_chip_mode <= 1'b1;
        acc(1'b1, 24'h000040, 16'h0000);
        chk(24'({err_seen, cs_seen}), 24'h000020);
        end_of_test();
    end
endmodule // xbu_core_tb
`default_nettype wire
